/* src/uart_rx_wake.v */
// Asynchronous serial receiver with address filter, auto wake-up and AXI4-Lite registers
`timescale 1ns/1ps
`include "uart_rx_regs.vh"

// Operation
// - Async mode: sync clear, port enabled
// - Divisor registers plus speed bits set rate
// - Nine-bit mode captures nine data bits
// - Address filter bit enables address detection
// - No filter: every character loaded, flagged, except one arriving while done is still set (overrun)
// - Receive only while continuous enable set
// - Done flag; interrupt needs both enables
// - Priority bit picks high or low
// - Status shows errors and ninth bit
// - Clearing continuous enable clears errors
// - Unimplemented bits read as zero
// - Sleep stops baud generator and reception
// - Wake enable at baud control bit 1
// - Wake mode suppresses reception, watches line
// - Falling edge on input is wake event
// - Wake event raises the done flag
// - Data read clears done flag
// - First rising edge clears wake enable
// - Input ticked at 64, 16 or 4 times baud, by speed bits
// - Idle flag low shows reception in progress
module uart_rx_wake (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire sleep_mode,
  input wire serial_input_line,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output wire irq_high,
  output wire irq_low
);

  // ====================================================
  // Receiver states, one-hot so each state is one flip-flop
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_STOP = 4'b1000;

  // Register copies, receiver state and bus capture
  reg [7:0] rx_status_ff;
  reg [7:0] rx_data_ff;
  reg [7:0] tx_status_ff;
  reg [7:0] baud_ctrl_ff;
  reg [7:0] div_high_ff;
  reg [7:0] div_low_ff;
  reg [7:0] irq_ctrl_ff;
  reg done_ff;
  reg wake_seen_ff;
  reg [3:0] state_ff;
  reg [6:0] tick_cnt_ff;
  reg [3:0] bit_cnt_ff;
  reg [8:0] shift_ff;
  reg [15:0] brg_cnt_ff;
  reg sync1_ff;
  reg sync2_ff;
  reg line_prev_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] aw_addr_ff;
  reg [7:0] w_data_ff;
  reg w_lane_ff;
  reg [7:0] rd_mux;
  reg rd_hit;
  reg [6:0] bit_ticks;

  // Field views of the control registers
  wire port_en = rx_status_ff[`RS_PORT_EN];
  wire nine_bit = rx_status_ff[`RS_NINE_BIT];
  wire cont_en = rx_status_ff[`RS_CONT_EN];
  wire addr_en = rx_status_ff[`RS_ADDR_EN];
  wire over_err = rx_status_ff[`RS_OVER_ERR];
  wire sync_mode = tx_status_ff[`TS_SYNC];
  wire high_speed = tx_status_ff[`TS_HIGH_SPEED];
  wire wide_div = baud_ctrl_ff[`BC_WIDE_DIV];
  wire wake_en = baud_ctrl_ff[`BC_WAKE];
  wire line = sync2_ff;
  wire line_fall = line_prev_ff & ~line;
  wire line_rise = ~line_prev_ff & line;
  // Idle flag: high whenever no character is being assembled
  wire rx_idle = state_ff[0];

  // ====================================================
  // Baud generator and mode gating
  // Async receive needs port on and sync off; overrun halts it until cleared
  wire async_on = port_en & ~sync_mode;
  // Wake mode and sleep both hold the receiver idle
  wire rx_allowed = async_on & cont_en & ~over_err & ~wake_en & ~sleep_mode;
  // Narrow divisor ignores the high byte
  wire [15:0] divisor = wide_div ? {div_high_ff, div_low_ff} : {8'h00, div_low_ff};
  wire brg_run = async_on & ~sleep_mode;
  // One tick every divisor plus one clocks
  wire tick = brg_run & (brg_cnt_ff == divisor);

  // Ticks per bit from the speed select pair
  // Limitation: one sample per bit at a fixed point, no majority vote
  always @* begin
    case ({wide_div, high_speed})
      2'b00: bit_ticks = `BT_SLOW;
      2'b11: bit_ticks = `BT_FAST;
      default: bit_ticks = `BT_MID;
    endcase
  end

  wire [6:0] half_ticks = {1'b0, bit_ticks[6:1]};
  // Index of the final data bit for the selected width
  wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;
  wire bit_done = tick & (tick_cnt_ff == bit_ticks - 7'h01);
  wire half_done = tick & (tick_cnt_ff == half_ticks - 7'h01);

  // ====================================================
  // AXI4-Lite handshake
  // Address and data may arrive in either order; the commit waits for both
  // One write and one read outstanding, so readies drop while answered
  wire wr_fire = aw_got_ff & w_got_ff & ~bvalid;
  assign awready = ce & ~aw_got_ff & ~bvalid;
  assign wready = ce & ~w_got_ff & ~bvalid;
  assign arready = ce & ~rvalid;
  wire rd_take = arvalid & arready;
  wire wr_low = wr_fire & w_lane_ff;
  // Reading the data register is how software clears the done flag
  wire data_read = rd_take & (araddr == `OFS_RX_DATA);

  // Read multiplexer; bits without storage read as zero
  always @* begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    case (araddr)
      `OFS_RX_STATUS: rd_mux = rx_status_ff;
      `OFS_RX_DATA: rd_mux = rx_data_ff;
      `OFS_TX_STATUS: rd_mux = tx_status_ff & 8'h14;
      `OFS_BAUD_CTRL: rd_mux = {1'b0, rx_idle, 6'h00} | (baud_ctrl_ff & 8'h0a);
      `OFS_DIV_HIGH: rd_mux = div_high_ff;
      `OFS_DIV_LOW: rd_mux = div_low_ff;
      `OFS_IRQ_CTRL: rd_mux = {4'h0, done_ff, irq_ctrl_ff[2:0]};
      default: rd_hit = 1'b0;
    endcase
  end

  // Write side collects address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (awvalid & awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid & wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= wdata[7:0];
        w_lane_ff <= wstrb[0];
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid <= 1'b1;
        case (aw_addr_ff)
          `OFS_RX_STATUS, `OFS_TX_STATUS, `OFS_BAUD_CTRL, `OFS_DIV_HIGH, `OFS_DIV_LOW,
          `OFS_IRQ_CTRL, `OFS_RX_DATA: bresp <= `RESP_OKAY;
          default: bresp <= `RESP_SLVERR;
        endcase
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read side answers one cycle after the address is taken
  // Read data are registered so they stand unchanged until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_mux};
        rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ====================================================
  // Input synchroniser and edge history
  // Reset to the idle-high level so leaving reset shows no false edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      line_prev_ff <= 1'b1;
    end else if (ce) begin
      sync1_ff <= serial_input_line;
      sync2_ff <= sync1_ff;
      line_prev_ff <= sync2_ff;
    end
  end

  // Baud counter restarts on each tick
  // Held at zero while stopped, so the first tick is a full period away
  always @(posedge aclk) begin
    if (!aresetn) begin
      brg_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (!brg_run || tick) begin
        brg_cnt_ff <= 16'h0000;
      end else begin
        brg_cnt_ff <= brg_cnt_ff + 16'h0001;
      end
    end
  end

  // ====================================================
  // Character receiver, sampled in ticks of the baud generator
  // Gated by the enable too, so a receiver stopped mid-stop-bit loads nothing
  wire char_end = rx_allowed & (state_ff == ST_STOP) & bit_done;
  wire keep_char = ~(addr_en & nine_bit & ~shift_ff[8]);
  wire overrun = char_end & keep_char & done_ff & ~data_read;
  wire load_char = char_end & keep_char & ~overrun;
  // Wake detection ignores sleep: the synchroniser keeps running
  wire wake_event = wake_en & ~wake_seen_ff & line_fall;
  wire wake_end = wake_en & wake_seen_ff & line_rise;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      tick_cnt_ff <= 7'h00;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 9'h000;
    end else if (ce) begin
      // Dropping the enable abandons a half-received character
      if (!rx_allowed) begin
        state_ff <= ST_IDLE;
      end else begin
        if (tick) begin
          tick_cnt_ff <= tick_cnt_ff + 7'h01;
        end
        case (state_ff)
          ST_IDLE: begin
            tick_cnt_ff <= 7'h00;
            if (line_fall) begin
              state_ff <= ST_START;
            end
          end
          ST_START: begin
            // Mid-bit check rejects short glitches as false starts
            if (half_done) begin
              tick_cnt_ff <= 7'h00;
              bit_cnt_ff <= 4'h0;
              state_ff <= line ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (bit_done) begin
              tick_cnt_ff <= 7'h00;
              // Nine-bit mode keeps bit 8; eight-bit mode leaves it zero
              shift_ff <= nine_bit ? {line, shift_ff[8:1]} : {1'b0, line, shift_ff[7:1]};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == last_bit) begin
                state_ff <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            // Stop level is judged at mid-bit, like the data bits
            if (bit_done) begin
              tick_cnt_ff <= 7'h00;
              state_ff <= ST_IDLE;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ====================================================
  // Register file and flags; hardware sets win over clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_status_ff <= `RST_RX_STATUS;
      rx_data_ff <= 8'h00;
      tx_status_ff <= `RST_TX_STATUS;
      baud_ctrl_ff <= `RST_BAUD_CTRL;
      div_high_ff <= `RST_DIV;
      div_low_ff <= `RST_DIV;
      irq_ctrl_ff <= `RST_IRQ_CTRL;
      done_ff <= 1'b0;
      wake_seen_ff <= 1'b0;
    end else if (ce) begin
      // Only byte lane 0 carries register data
      if (wr_low) begin
        case (aw_addr_ff)
          `OFS_RX_STATUS: begin
            // Error and ninth-bit fields are read-only
            rx_status_ff[7:3] <= w_data_ff[7:3];
          end
          `OFS_TX_STATUS: tx_status_ff <= w_data_ff & 8'h14;
          `OFS_BAUD_CTRL: baud_ctrl_ff <= w_data_ff & 8'h0a;
          `OFS_DIV_HIGH: div_high_ff <= w_data_ff;
          `OFS_DIV_LOW: div_low_ff <= w_data_ff;
          `OFS_IRQ_CTRL: irq_ctrl_ff <= w_data_ff & 8'h07;
          default: ;
        endcase
      end
      // Error flags are held low while continuous receive is off
      if (!cont_en) begin
        rx_status_ff[`RS_FRAME_ERR] <= 1'b0;
        rx_status_ff[`RS_OVER_ERR] <= 1'b0;
      end
      // Overrun halts the receiver until continuous receive is toggled
      if (overrun) begin
        rx_status_ff[`RS_OVER_ERR] <= 1'b1;
      end
      if (load_char) begin
        rx_data_ff <= shift_ff[7:0];
        rx_status_ff[`RS_NINTH] <= shift_ff[8];
        rx_status_ff[`RS_FRAME_ERR] <= ~line;
      end
      // Done flag: read of data clears, new character or wake sets
      // A wake read-out returns whatever character was last loaded
      if (load_char | wake_event) begin
        done_ff <= 1'b1;
      end else if (data_read) begin
        done_ff <= 1'b0;
      end
      // The event arms the end detector, a rising edge disarms it
      if (wake_event) begin
        wake_seen_ff <= 1'b1;
      end else if (wake_end | ~wake_en) begin
        wake_seen_ff <= 1'b0;
      end
      // Hardware ends wake mode on the first rising edge after the event
      if (wake_end) begin
        baud_ctrl_ff[`BC_WAKE] <= 1'b0;
      end
    end
  end

  // ====================================================
  // Interrupt outputs, split by priority
  // Levels, not pulses: they fall when the done flag or an interrupt enable is cleared
  wire irq_pend = done_ff & irq_ctrl_ff[`IC_ENABLE] & irq_ctrl_ff[`IC_GLOBAL];
  assign irq_high = irq_pend & irq_ctrl_ff[`IC_PRIORITY];
  assign irq_low = irq_pend & ~irq_ctrl_ff[`IC_PRIORITY];

endmodule // uart_rx_wake

/* src/uart_rx_regs.vh */
// Register offsets, field positions, reset values and timing counts of the serial receiver
`ifndef UART_RX_REGS_VH
`define UART_RX_REGS_VH
// ====================================================
// Register byte offsets
`define OFS_RX_STATUS 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_TX_STATUS 8'h08
`define OFS_BAUD_CTRL 8'h0c
`define OFS_DIV_HIGH 8'h10
`define OFS_DIV_LOW 8'h14
`define OFS_IRQ_CTRL 8'h18
// ====================================================
// Receive status/control fields
`define RS_PORT_EN 7
`define RS_NINE_BIT 6
`define RS_SINGLE_EN 5
`define RS_CONT_EN 4
`define RS_ADDR_EN 3
`define RS_FRAME_ERR 2
`define RS_OVER_ERR 1
`define RS_NINTH 0
// Transmit status/control fields used here
`define TS_SYNC 4
`define TS_HIGH_SPEED 2
// Baud control fields
`define BC_IDLE 6
`define BC_WIDE_DIV 3
`define BC_WAKE 1
// Interrupt control fields
`define IC_ENABLE 0
`define IC_PRIORITY 1
`define IC_GLOBAL 2
`define IC_DONE 3
// ====================================================
// Reset values
`define RST_RX_STATUS 8'h00
`define RST_TX_STATUS 8'h00
`define RST_BAUD_CTRL 8'h00
`define RST_DIV 8'h00
`define RST_IRQ_CTRL 8'h00
// ====================================================
// Baud ticks per bit for each speed setting (x16 sampling base)
`define BT_SLOW 7'h40
`define BT_MID 7'h10
`define BT_FAST 7'h04
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* test/uart_rx_wake_chk.sv */
// Assertion checker for the receiver register bus and interrupt outputs
`timescale 1ns/1ps
`include "uart_rx_regs.vh"
module uart_rx_wake_chk (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  input wire irq_high,
  input wire irq_low
);
  // ====
  // Single domain, so one clocking and one disable for all
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_irq_one_level: assert property (!(irq_high && irq_low)) else $error("both irq levels high");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rvalid dropped");
  // Commit edge sits between the take and the response, so bvalid is seen two edges on
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("no bvalid");
  a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("no rvalid");
  a_read_refused: assert property (rvalid |-> !arready) else $error("arready while rvalid");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_hole_error: assert property (arvalid && arready && araddr > 8'h1b |=>
    rresp == `RESP_SLVERR && rdata == 32'h0000_0000) else $error("hole read not refused");
  a_read_clears: assert property (arvalid && arready && araddr == `OFS_RX_DATA |=> ##1
    !irq_high && !irq_low) else $error("irq kept after data read");
  // Main scenarios seen
  cover property (irq_high);
  cover property (irq_low);
  cover property (arvalid && arready && araddr == `OFS_RX_DATA);
endmodule // uart_rx_wake_chk
bind uart_rx_wake uart_rx_wake_chk chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq_high, .irq_low);

/* test/serial_tx_model.sv */
// Behavioural remote transmitter on the receive line
`timescale 1ns/1ps
module serial_tx_model (
  input wire aclk,
  output logic line
);
  int bit_clks = 16;
  initial line = 1'b1;
  // ====
  // One frame, LSB first; stop level is chosen so framing faults can be forced
  task send(input [8:0] v, input int n, input logic stop);
    begin
      line <= 1'b0;
      repeat (bit_clks) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
        line <= v[i];
        repeat (bit_clks) @(posedge aclk);
      end
      line <= stop;
      repeat (bit_clks) @(posedge aclk);
      line <= 1'b1;
      @(posedge aclk); // Idle cycle keeps frames apart
    end
  endtask
  // Wake character all zero, long, so no early rising edge ends the wake
  task wake(input int bits);
    begin
      line <= 1'b0;
      repeat (bits * bit_clks) @(posedge aclk);
      line <= 1'b1;
    end
  endtask
endmodule // serial_tx_model

/* test/tb.sv */
// Self-checking bench for the receiver with address filter and wake-up
`timescale 1ns/1ps
`include "uart_rx_regs.vh"
module tb;
  logic aclk = 0, aresetn = 0, sleep_mode = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, v;
  logic [31:0] wdata = 0, d;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, irq_high, irq_low, line;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int fail_count = 0, checks_done = 0, bt, dv;
  uart_rx_wake uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .sleep_mode(sleep_mode), .serial_input_line(line),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq_high(irq_high),
    .irq_low(irq_low));
  serial_tx_model m (.aclk(aclk), .line(line));
  always #20 aclk = ~aclk;
  // ====
  // Bus tasks sample at the falling edge, where readies have settled
  task wr(input [7:0] a, input [31:0] dd);
    logic at, wt, bt_;
    begin
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
        @(negedge aclk);
        at = awvalid & awready;
        wt = wvalid & wready;
        bt_ = bvalid;
        @(posedge aclk);
        if (at) awvalid <= 0;
        if (wt) wvalid <= 0;
        if (bt_) bready <= 0;
      end while (!bt_);
      @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a, output [31:0] dd, output [1:0] rr);
    logic at, t;
    begin
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
        @(negedge aclk);
        at = arvalid & arready;
        t = rvalid;
        dd = rdata;
        rr = rresp;
        @(posedge aclk);
        if (at) arvalid <= 0;
        if (t) rready <= 0;
      end while (!t);
      @(posedge aclk);
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      checks_done++;
      if (g !== e) begin
        fail_count++;
        $display("[ERR] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      rd(a, d, r);
      chk("rdata", e, d);
      chk("rresp", 32'(er), 32'(r));
    end
  endtask
  function [31:0] st(input [7:0] c, input fe, input oe, input n9);
    st = {24'h00_0000, c[7:3], fe, oe, n9};
  endfunction
  task frame(input [8:0] x, input int n, input logic s);
    begin
      m.send(x, n, s);
      repeat (bt) @(posedge aclk);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ====
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    conclude();
  end
  initial begin
    dv = $urandom(14);
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(`OFS_RX_STATUS, 32'h0000_0000, `RESP_OKAY);
    rc(`OFS_BAUD_CTRL, 32'h0000_0040, `RESP_OKAY);
    rc(8'h20, 32'h0000_0000, `RESP_SLVERR);
    dv = $urandom % 3 + 1;
    bt = (dv + 1) * 4;
    m.bit_clks = bt;
    wr(`OFS_TX_STATUS, 32'h0000_0004);
    wr(`OFS_BAUD_CTRL, 32'h0000_0008);
    wr(`OFS_DIV_LOW, dv);
    // Low priority, high priority, then global off
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_IRQ_CTRL, k == 0 ? 5 : k == 1 ? 7 : 3);
      wr(`OFS_RX_STATUS, 32'h0000_0090);
      v = $urandom;
      frame(v, 8, 1'b1);
      chk("irq_low", k == 0, irq_low);
      chk("irq_high", k == 1, irq_high);
      rc(`OFS_RX_STATUS, st(8'h90, 0, 0, 0), `RESP_OKAY);
      rc(`OFS_RX_DATA, v, `RESP_OKAY);
      rc(`OFS_IRQ_CTRL, k == 0 ? 5 : k == 1 ? 7 : 3, `RESP_OKAY);
    end
    // Address filter drops ninth-bit-zero characters
    wr(`OFS_RX_STATUS, 32'h0000_00d8);
    for (int k = 0; k < 2; k++) begin
      v = $urandom;
      frame({k[0], v}, 9, 1'b1);
      rc(`OFS_IRQ_CTRL, {k[0], 3'h3}, `RESP_OKAY);
      if (k) rc(`OFS_RX_STATUS, st(8'hd8, 0, 0, 1), `RESP_OKAY);
      if (k) rc(`OFS_RX_DATA, v, `RESP_OKAY);
    end
    // Framing error, clearing it, and no reception while disabled
    wr(`OFS_RX_STATUS, 32'h0000_0090);
    frame(9'h05a, 8, 1'b0);
    rc(`OFS_RX_STATUS, st(8'h90, 1, 0, 0), `RESP_OKAY);
    rc(`OFS_RX_DATA, 32'h0000_005a, `RESP_OKAY);
    wr(`OFS_RX_STATUS, 32'h0000_0080);
    rc(`OFS_RX_STATUS, st(8'h80, 0, 0, 0), `RESP_OKAY);
    frame(9'h033, 8, 1'b1);
    rc(`OFS_IRQ_CTRL, 32'h0000_0003, `RESP_OKAY);
    // Overrun on a second unread character keeps the first
    wr(`OFS_RX_STATUS, 32'h0000_0090);
    v = $urandom;
    m.send(v, 8, 1'b1);
    frame(~v, 8, 1'b1);
    rc(`OFS_RX_STATUS, st(8'h90, 0, 1, 0), `RESP_OKAY);
    rc(`OFS_RX_DATA, v, `RESP_OKAY);
    wr(`OFS_RX_STATUS, 32'h0000_0080);
    rc(`OFS_RX_STATUS, st(8'h80, 0, 0, 0), `RESP_OKAY);
    wr(`OFS_RX_STATUS, 32'h0000_0090);
    // Sleep without wake receives nothing
    sleep_mode <= 1;
    frame(9'h0a5, 8, 1'b1);
    rc(`OFS_IRQ_CTRL, 32'h0000_0003, `RESP_OKAY);
    wr(`OFS_BAUD_CTRL, 32'h0000_000a);
    fork
      m.wake(12);
      begin
        repeat (bt * 4) @(posedge aclk);
        rc(`OFS_IRQ_CTRL, 32'h0000_000b, `RESP_OKAY);
        rc(`OFS_BAUD_CTRL, 32'h0000_004a, `RESP_OKAY);
      end
    join
    repeat (bt) @(posedge aclk);
    rc(`OFS_BAUD_CTRL, 32'h0000_0048, `RESP_OKAY);
    rd(`OFS_RX_DATA, d, r);
    chk("rresp", 32'(`RESP_OKAY), 32'(r));
    rc(`OFS_IRQ_CTRL, 32'h0000_0003, `RESP_OKAY);
    sleep_mode <= 0;
    v = $urandom;
    // Idle flag must drop while a character is being assembled
    fork
      m.send(v, 8, 1'b1);
      begin
        repeat (bt * 3) @(posedge aclk);
        rc(`OFS_BAUD_CTRL, 32'h0000_0008, `RESP_OKAY);
      end
    join
    repeat (bt) @(posedge aclk);
    rc(`OFS_RX_DATA, v, `RESP_OKAY);
    conclude();
  end
endmodule // tb
